//--- shared/boot_pkg.sv
// Behaviour
// - Reset low holds device in reset state
// - Release starts with mode sampled then
// - Host boot stalls CPU, rest runs
// - Host may load memory during stall
// - Strap 0 parallel port, 1 PCI
// - Host sets interrupt bit to finish
// - Interrupt bit releases CPU at address 0
// - Boot interrupt not latched as pending
// - Bit releases stall only in host boot
// - Host may write and read memory
// - Flag stays until CPU clears; blocks more
// - DMA copies 1K image from space one
// - Pack four ROM bytes per word
// - ROM holds system byte order
// - Copy is one single-frame block
// - Copy done releases CPU at address 0
// - No boot runs at 0 at once
// - System keeps valid code at 0
package boot_pkg;
  // ---------------------------------------------------------------------
  // Modes, sizes and addresses
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_HOST,
    MODE_EMEM
  } boot_mode_e;
  localparam int unsigned IMAGE_BYTES = 1024;
  localparam int unsigned BYTES_PER_WORD = 4;
  localparam int unsigned IMAGE_WORDS = IMAGE_BYTES / BYTES_PER_WORD;
  localparam logic [31:0] START_ADDR = 32'h0000_0000;
  localparam logic [31:0] SPACE_ONE_BASE = 32'h9000_0000;
  localparam logic STRAP_HPI = 1'b0;
  localparam logic STRAP_PCI = 1'b1;
endpackage

//--- shared/boot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface boot_if;
  logic [1:0] mode;
  logic pci_sel;
  logic host_wr;
  logic host_rd;
  logic [31:0] host_addr;
  logic [31:0] host_wdata;
  logic [31:0] host_rdata;
  logic host_rvalid;
  logic host_int_set;
  logic int_flag;
  logic rom_rd;
  logic [31:0] rom_addr;
  logic [7:0] rom_data;
  logic rom_valid;
  logic cpu_run;
  modport dev (
    input mode, pci_sel, host_wr, host_rd, host_addr, host_wdata,
    input host_int_set, rom_data, rom_valid,
    output host_rdata, host_rvalid, int_flag, rom_rd, rom_addr, cpu_run
  );
  modport host (
    output mode, pci_sel, host_wr, host_rd, host_addr, host_wdata,
    output host_int_set, rom_data, rom_valid,
    input host_rdata, host_rvalid, int_flag, rom_rd, rom_addr, cpu_run
  );
endinterface
`default_nettype wire

//--- hdl/byte_packer.sv
`timescale 1ns/1ps
`default_nettype none
module byte_packer
  import boot_pkg::*;
#(
  parameter int unsigned NBYTES = BYTES_PER_WORD
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic o_valid,
  output logic [8*NBYTES-1:0] o_word
);
  logic [$clog2(NBYTES)-1:0] idx_q;
  wire last = (idx_q == ($clog2(NBYTES))'(NBYTES - 1));
  // First byte lands lowest; ROM is stored in system order
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      idx_q <= '0;
      o_valid <= 1'b0;
      o_word <= '0;
    end else begin
      o_valid <= i_valid && last;
      if (i_valid) begin
        o_word[8*idx_q +: 8] <= i_byte;
        idx_q <= last ? '0 : idx_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/boot_seq_dev.sv
`timescale 1ns/1ps
`default_nettype none
module boot_seq_dev
  import boot_pkg::*;
#(
  parameter int unsigned WORDS = IMAGE_WORDS,
  parameter int unsigned MEM_WORDS = 1024
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  boot_if.dev bus,
  input wire logic i_cpu_int_clr,
  output logic o_cpu_run,
  output logic [31:0] o_cpu_pc,
  output logic o_cpu_int_pend,
  output logic o_route_pci,
  output logic o_copy_busy
);
  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_COPY, ST_RUN} st_e;
  st_e st_q;
  st_e st_d;
  logic [1:0] mode_q;
  logic flag_q;
  logic [31:0] rom_idx_q;
  logic [31:0] wr_idx_q;
  logic [31:0] mem [MEM_WORDS];
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic rom_rd_q;
  logic pack_valid;
  logic [31:0] pack_word;
  localparam int AW = $clog2(MEM_WORDS);

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  wire is_host = (mode_q == 2'(MODE_HOST));
  wire is_emem = (mode_q == 2'(MODE_EMEM));
  wire stalled = (st_q == ST_STALL);
  wire copying = (st_q == ST_COPY);
  wire set_take = bus.host_int_set && !flag_q;
  // Only host mode lets the set release the CPU
  wire release_host = stalled && is_host && set_take;
  wire [AW-1:0] haddr = bus.host_addr[AW+1:2];
  wire copy_done = copying && pack_valid && (wr_idx_q == WORDS - 1);
  wire rom_more = copying && (rom_idx_q < WORDS * BYTES_PER_WORD);
  // Straps are read off the pins for the first edge only
  wire pick_host = (bus.mode == 2'(MODE_HOST));
  wire pick_emem = (bus.mode == 2'(MODE_EMEM));
  wire sample_now = (st_q == ST_IDLE);

  byte_packer #(.NBYTES(BYTES_PER_WORD)) u_pack (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!copying),
    .i_valid(bus.rom_valid && copying),
    .i_byte(bus.rom_data),
    .o_valid(pack_valid),
    .o_word(pack_word)
  );

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        // Mode is looked at once, on the first edge out of reset
        if (pick_host) begin
          st_d = ST_STALL;
        end else if (pick_emem) begin
          st_d = ST_COPY;
        end else begin
          st_d = ST_RUN;
        end
      end
      ST_STALL: begin
        if (release_host) begin
          st_d = ST_RUN;
        end
      end
      ST_COPY: begin
        if (copy_done) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  wire run_d = (st_d == ST_RUN);
  wire busy_d = (st_d == ST_COPY);

  // Mode and strap sit in flops so a pin wiggle after release is harmless
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      mode_q <= 2'(MODE_NONE);
      o_cpu_run <= 1'b0;
      o_route_pci <= 1'b0;
      o_copy_busy <= 1'b0;
      o_cpu_pc <= START_ADDR;
    end else begin
      st_q <= st_d;
      o_cpu_run <= run_d;
      o_copy_busy <= busy_d;
      // Every mode starts the CPU at the same fixed address
      o_cpu_pc <= START_ADDR;
      if (sample_now) begin
        mode_q <= bus.mode;
        o_route_pci <= (bus.pci_sel == STRAP_PCI);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt flag
  // ---------------------------------------------------------------------
  // Flag: set wins over CPU clear; blocks repeat sets
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
      o_cpu_int_pend <= 1'b0;
    end else begin
      if (set_take) begin
        flag_q <= 1'b1;
      end else if (i_cpu_int_clr) begin
        flag_q <= 1'b0;
      end
      // A set while stalled is not seen as pending by the CPU
      if (set_take && st_q == ST_RUN) begin
        o_cpu_int_pend <= 1'b1;
      end else if (i_cpu_int_clr) begin
        o_cpu_int_pend <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Copy engine: one single-frame block from space one to 0
  // ---------------------------------------------------------------------
  // One read every other cycle gives the ROM a full cycle to answer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !copying) begin
      rom_idx_q <= '0;
      wr_idx_q <= '0;
      rom_rd_q <= 1'b0;
    end else begin
      rom_rd_q <= rom_more && !rom_rd_q;
      if (rom_rd_q) begin
        rom_idx_q <= rom_idx_q + 1;
      end
      if (pack_valid) begin
        wr_idx_q <= wr_idx_q + 1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Memory
  // ---------------------------------------------------------------------
  // No reset here: the host or the copy fills what the CPU runs.
  // Copy writes win; the host has no write path outside host mode.
  // Memory: host writes and reads whole space in host mode, stalled or running
  always_ff @(posedge i_clk) begin
    if (copying && pack_valid) begin
      mem[wr_idx_q[AW-1:0]] <= pack_word;
    end else if (bus.host_wr && is_host) begin
      mem[haddr] <= bus.host_wdata;
    end
  end

  // ---------------------------------------------------------------------
  // Host read port
  // ---------------------------------------------------------------------
  // Registered read data costs a cycle but keeps the path short
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.host_rd && is_host;
      rdata_q <= mem[haddr];
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign bus.host_rdata = rdata_q;
  assign bus.host_rvalid = rvalid_q;
  assign bus.int_flag = flag_q;
  assign bus.rom_rd = rom_rd_q;
  assign bus.rom_addr = SPACE_ONE_BASE + rom_idx_q;
  assign bus.cpu_run = o_cpu_run;
endmodule
`default_nettype wire

//--- hdl/boot_seq_host.sv
`timescale 1ns/1ps
`default_nettype none
module boot_seq_host
  import boot_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  boot_if.host bus,
  input wire logic [1:0] i_mode,
  input wire logic i_pci_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_done,
  input wire logic [7:0] i_rom_byte,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_cpu_run
);
  logic wr_q, rd_q, set_q, rv_q;
  logic [31:0] addr_q, wdata_q;
  logic [7:0] rom_q;
  // Host loads memory then sets the interrupt bit once
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      set_q <= 1'b0;
      rv_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      rom_q <= '0;
      o_rdata <= '0;
      o_rvalid <= 1'b0;
      o_cpu_run <= 1'b0;
    end else begin
      wr_q <= i_wr;
      rd_q <= i_rd;
      set_q <= i_done && !bus.int_flag;
      addr_q <= i_addr;
      wdata_q <= i_wdata;
      rom_q <= i_rom_byte;
      rv_q <= bus.rom_rd;
      o_rdata <= bus.host_rdata;
      o_rvalid <= bus.host_rvalid;
      o_cpu_run <= bus.cpu_run;
    end
  end
  assign bus.mode = i_mode;
  assign bus.pci_sel = i_pci_sel;
  assign bus.host_wr = wr_q;
  assign bus.host_rd = rd_q;
  assign bus.host_addr = addr_q;
  assign bus.host_wdata = wdata_q;
  assign bus.host_int_set = set_q;
  assign bus.rom_data = rom_q;
  assign bus.rom_valid = rv_q;
endmodule
`default_nettype wire

//--- sim/boot_properties.sv
`timescale 1ns/1ps
`default_nettype none
module boot_properties
  import boot_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] mode,
  input wire logic host_rd,
  input wire logic host_rvalid,
  input wire logic host_int_set,
  input wire logic int_flag,
  input wire logic rom_rd,
  input wire logic [31:0] rom_addr,
  input wire logic cpu_run
);
  // ------
  // Checks
  // ------
  // Read count since reset; a lost or extra read shows in the address
  logic [10:0] cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) cnt_q <= 11'h0;
    else if (rom_rd) cnt_q <= cnt_q + 11'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rd; host_rd |=> host_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_hold; cpu_run |=> cpu_run; endproperty
  a_hold: assert property (p_hold) else $error("run dropped");
  property p_stall; mode == 2'h1 && !cpu_run && !host_int_set |=> !cpu_run;
  endproperty
  a_stall: assert property (p_stall) else $error("early run");
  property p_rel; mode == 2'h1 && host_int_set && !int_flag &&
    $past(i_rst_n) |=> cpu_run; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_flag; host_int_set |=> int_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_none; mode == 2'h0 && $past(i_rst_n) |-> cpu_run; endproperty
  a_none: assert property (p_none) else $error("no-boot stalled");
  property p_copy; mode == 2'h2 && cnt_q < 11'h400 |-> !cpu_run; endproperty
  a_copy: assert property (p_copy) else $error("run before copy");
  property p_addr; rom_rd |-> rom_addr == SPACE_ONE_BASE + {21'h0, cnt_q};
  endproperty
  a_addr: assert property (p_addr) else $error("rom address");
  property p_gap; rom_rd |=> !rom_rd; endproperty
  a_gap: assert property (p_gap) else $error("rom pacing");
  property p_done; mode == 2'h2 && cnt_q == 11'h400 |-> ##[0:8] cpu_run;
  endproperty
  a_done: assert property (p_done) else $error("no copy release");
endmodule
`default_nettype wire

//--- sim/boot_mode_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boot_mode_sequencer_tb
  import boot_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic pci = 1'b0, wr = 1'b0, rd = 1'b0, done = 1'b0, clr = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, pc;
  logic [7:0] rom_byte = 8'h0;
  logic rvalid, run, pend, route, busy;
  logic [31:0] seed = 32'hc3b2;
  logic [31:0] exp_q[$];
  logic [31:0] ref_m [8];
  int mismatches = 0, checks = 0;
  always #2.5 i_clk = ~i_clk;
  boot_if bif();
  boot_seq_host boot_seq_host_inst(.i_clk(i_clk), .i_rst_n(i_rst_n),
    .bus(bif.host), .i_mode(mode), .i_pci_sel(pci), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .i_done(done), .i_rom_byte(rom_byte),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_cpu_run());
  boot_seq_dev boot_seq_dev_inst(.i_clk(i_clk), .i_rst_n(i_rst_n),
    .bus(bif.dev), .i_cpu_int_clr(clr), .o_cpu_run(run), .o_cpu_pc(pc),
    .o_cpu_int_pend(pend), .o_route_pci(route), .o_copy_busy(busy));
  boot_properties boot_properties_inst(.i_clk(i_clk), .i_rst_n(i_rst_n),
    .mode(bif.mode), .host_rd(bif.host_rd), .host_rvalid(bif.host_rvalid),
    .host_int_set(bif.host_int_set), .int_flag(bif.int_flag),
    .rom_rd(bif.rom_rd), .rom_addr(bif.rom_addr), .cpu_run(bif.cpu_run));
  // ----------
  // Bench jobs
  // ----------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic boot(input logic [1:0] m, input logic p);
    i_rst_n = 1'b0;
    mode = m;
    pci = p;
    repeat (8) @(negedge i_clk);
    check(32'(run), 32'h0);
    check(32'(bif.int_flag), 32'h0);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    check(32'(route), 32'(p));
  endtask
  task automatic access(input logic w, input int i, input logic [31:0] d);
    wr = w;
    rd = !w;
    addr = {20'h0, 10'(i), 2'h0};
    wdata = d;
    if (!w) exp_q.push_back(d);
    @(negedge i_clk);
    wr = 1'b0;
    rd = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic pulse(input logic c);
    clr = c;
    done = !c;
    @(negedge i_clk);
    {clr, done} = 2'h0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic wait_run(input int n);
    for (int i = 0; i < n && run !== 1'b1; i++) @(negedge i_clk);
    if (run !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  // Read data is checked where it shows, against the note left by the driver
  always @(negedge i_clk) begin
    if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
  end
  // A released ROM bus shows inverted data rather than a stale byte
  always @(negedge i_clk) begin
    if (bif.rom_rd === 1'b1) rom_byte <= bif.rom_addr[7:0] ^ 8'h5a;
    else rom_byte <= ~rom_byte;
  end
  initial begin
    boot(2'h0, 1'b0);
    check(32'(run), 32'h1);
    check(pc, START_ADDR);
    pulse(1'b0);
    check(32'(bif.int_flag), 32'h1);
    $display("no-boot test done");
    boot(2'h1, 1'b1);
    check(32'(run), 32'h0);
    for (int i = 0; i < 8; i++) begin
      ref_m[i] = rnd();
      access(1'b1, i * 131, ref_m[i]);
    end
    for (int i = 0; i < 8; i++) access(1'b0, i * 131, ref_m[i]);
    repeat (3) @(negedge i_clk);
    check(32'(exp_q.size()), 32'h0);
    pulse(1'b0);
    wait_run(4);
    check(pc, START_ADDR);
    check(32'(pend), 32'h0);
    pulse(1'b0);
    check(32'(pend), 32'h0);
    pulse(1'b1);
    pulse(1'b0);
    check(32'(pend), 32'h1);
    $display("host test done");
    boot(2'h2, 1'b0);
    pulse(1'b0);
    check(32'(run), 32'h0);
    check(32'(busy), 32'h1);
    wait_run(2400);
    check(32'(busy), 32'h0);
    check(pc, START_ADDR);
    check(boot_seq_dev_inst.mem[0], 32'h59585b5a);
    check(boot_seq_dev_inst.mem[255], 32'ha5a4a7a6);
    $display("copy test done");
    complete_run();
  end
endmodule
`default_nettype wire
